/* rtl/dqsf_params.svh */
// Summary of operation
// - Reset pin low for the minimum pulse aborts work and floats outputs.
// - Hardware reset restores volatile configuration and status bits.
// - Hardware reset clears the bank address register.
// - Hardware reset fills the program buffer with ones.
// - Reset reloads configuration, returns to standby within the power-up time.
// - Instruction bits travel only on the lowest line of each lane.
// - Data uses all eight lines, one byte per transfer.
// - Instruction, address and input data are captured on rising clock edges in SDR.
// - Output changes after falling edges in SDR, every edge in DDR.
// - Chip select high: inputs ignored, outputs floated.
// - Standby power when deselected and idle; active power when selected.
// - After power-up no command until a chip-select falling edge.
// - Only SDR modes 0 and 3: capture rising, drive from falling.
// - Clock cycles run fall to fall; mode 0 starts at select.
// - DDR instruction on rising edges; address and data on both edges.
// - First DDR address bit on first rise after instruction ends.
// - DDR read data starts on the fall ending the last dummy cycle.
// - Lowest line holds least significant bit; most significant first.
// - Every command opens with eight instruction bits on one line.
`ifndef DQSF_PARAMS_SVH
`define DQSF_PARAMS_SVH

`define DQSF_CLK_MHZ 100
`define DQSF_RESET_PULSE_MIN_NS 200
`define DQSF_POWER_UP_TIME_US 300
`define DQSF_INSTR_BITS 4'h8
`define DQSF_NIB_ADDR24 4'h6
`define DQSF_NIB_ADDR32 4'h8
`define DQSF_NIB_MODE 4'h2
`define DQSF_CFG_VOL_RST 8'h00
`define DQSF_STAT_VOL_RST 8'h00
`define DQSF_BANK_RST 8'h00
`define DQSF_OE_ALL 8'hFF
`define DQSF_OE_NONE 8'h00

`endif

/* rtl/dqsf_pkg.sv */
package dqsf_pkg;

    typedef enum logic [3:0] {
        ST_INIT,
        ST_IDLE,
        ST_INSTR,
        ST_DECODE,
        ST_ADDR,
        ST_MODE,
        ST_DUMMY,
        ST_DIN,
        ST_DOUT,
        ST_DONE
    } dqsf_state_t;

endpackage : dqsf_pkg

/* rtl/dqsf_frontend.sv */
`timescale 1ns/100ps
`include "dqsf_params.svh"

module dqsf_frontend #(
    parameter int unsigned PU_CYCLES =
        `DQSF_POWER_UP_TIME_US * `DQSF_CLK_MHZ
) (
    // System clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // Link pins
    input wire logic hw_reset_n_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic [7:0] io_i,
    output logic [7:0] io_o,
    output logic [7:0] io_oe_o,
    // Command decode handshake with the core
    output logic [7:0] instr_o,
    output logic instr_valid_o,
    input wire logic fmt_addr_en_i,
    input wire logic fmt_addr32_i,
    input wire logic fmt_mode_en_i,
    input wire logic fmt_ddr_i,
    input wire logic [4:0] fmt_dummy_i,
    input wire logic fmt_read_i,
    input wire logic fmt_write_i,
    // Address, mode and data to and from the core
    output logic [31:0] addr_o,
    output logic addr_valid_o,
    output logic [7:0] mode_o,
    output logic [7:0] wr_data_o,
    output logic wr_valid_o,
    input wire logic [7:0] rd_data_i,
    output logic rd_req_o,
    output logic cmd_end_o,
    // Volatile registers
    input wire logic cfg_wr_i,
    input wire logic [7:0] cfg_wdata_i,
    input wire logic stat_wr_i,
    input wire logic [7:0] stat_wdata_i,
    input wire logic bank_wr_i,
    input wire logic [7:0] bank_wdata_i,
    output logic [7:0] cfg_vol_o,
    output logic [7:0] stat_vol_o,
    output logic [7:0] bank_addr_o,
    // Power and initialisation status
    input wire logic embedded_busy_i,
    output logic prog_buf_fill_o,
    output logic init_busy_o,
    output logic active_power_o,
    output logic standby_o
);

    localparam int RP_NS = `DQSF_RESET_PULSE_MIN_NS;
    localparam int RP_CYC_RAW = (RP_NS * `DQSF_CLK_MHZ + 999) / 1000;
    localparam int RP_CYC = (RP_CYC_RAW < 1) ? 1 : RP_CYC_RAW;

    function automatic dqsf_pkg::dqsf_state_t data_phase(
        input logic rd,
        input logic wr
    );
        if (rd)
        begin
            return dqsf_pkg::ST_DUMMY;
        end
        else if (wr)
        begin
            return dqsf_pkg::ST_DIN;
        end
        return dqsf_pkg::ST_DONE;
    endfunction : data_phase

    // In DDR the last address or mode nibble already closes on a fall.
    function automatic logic [4:0] dummy_load(
        input logic ddr,
        input logic [4:0] n
    );
        if (ddr && n != 5'h00)
        begin
            return n - 5'h01;
        end
        return n;
    endfunction : dummy_load

    // Two-stage synchronisers; the third stage only feeds edge detection.
    logic rst_s1, rst_s2;
    logic sclk_s1, sclk_s2, sclk_s3;
    logic cs_s1, cs_s2, cs_s3;
    logic [7:0] io_s1, io_s2;

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            rst_s1 <= 1'b1;
            rst_s2 <= 1'b1;
            sclk_s1 <= 1'b0;
            sclk_s2 <= 1'b0;
            sclk_s3 <= 1'b0;
            cs_s1 <= 1'b1;
            cs_s2 <= 1'b1;
            cs_s3 <= 1'b1;
            io_s1 <= 8'h00;
            io_s2 <= 8'h00;
        end
        else
        begin
            rst_s1 <= hw_reset_n_i;
            rst_s2 <= rst_s1;
            sclk_s1 <= sclk_i;
            sclk_s2 <= sclk_s1;
            sclk_s3 <= sclk_s2;
            cs_s1 <= cs_n_i;
            cs_s2 <= cs_s1;
            cs_s3 <= cs_s2;
            io_s1 <= io_i;
            io_s2 <= io_s1;
        end
    end

    logic rise, fall, cs_fall;
    assign rise = sclk_s2 & ~sclk_s3;
    assign fall = ~sclk_s2 & sclk_s3;
    assign cs_fall = ~cs_s2 & cs_s3;

    dqsf_pkg::dqsf_state_t state, next_state;
    logic [7:0] rp_cnt, next_rp_cnt;
    logic [31:0] pu_cnt, next_pu_cnt;
    logic [3:0] bit_cnt, next_bit_cnt;
    logic [4:0] dmy_cnt, next_dmy_cnt;
    logic [7:0] instr, next_instr;
    logic [31:0] addr, next_addr;
    logic [7:0] mode, next_mode;
    logic f_addr_en, f_addr32, f_mode_en, f_ddr, f_read, f_write;
    logic next_f_addr_en, next_f_addr32, next_f_mode_en;
    logic next_f_ddr, next_f_read, next_f_write;
    logic [4:0] f_dummy, next_f_dummy;
    logic [7:0] dout, next_dout;
    logic [7:0] oe, next_oe;
    logic [7:0] wr_data, next_wr_data;
    logic instr_valid, next_instr_valid;
    logic addr_valid, next_addr_valid;
    logic wr_valid, next_wr_valid;
    logic rd_req, next_rd_req;
    logic cmd_end, next_cmd_end;
    logic [7:0] cfg_vol, next_cfg_vol;
    logic [7:0] stat_vol, next_stat_vol;
    logic [7:0] bank, next_bank;
    logic rst_taken;
    logic cap, upd;
    logic [3:0] addr_nibs;

    assign rst_taken = (rp_cnt == 8'(RP_CYC));
    // Capture edges: rising only, plus falling after a DDR instruction.
    assign cap = rise | (f_ddr & fall);
    assign upd = fall | (f_ddr & rise);
    assign addr_nibs = f_addr32 ? `DQSF_NIB_ADDR32 : `DQSF_NIB_ADDR24;

    always_comb
    begin
        next_state = state;
        next_rp_cnt = rp_cnt;
        next_pu_cnt = pu_cnt;
        next_bit_cnt = bit_cnt;
        next_dmy_cnt = dmy_cnt;
        next_instr = instr;
        next_addr = addr;
        next_mode = mode;
        next_f_addr_en = f_addr_en;
        next_f_addr32 = f_addr32;
        next_f_mode_en = f_mode_en;
        next_f_ddr = f_ddr;
        next_f_read = f_read;
        next_f_write = f_write;
        next_f_dummy = f_dummy;
        next_dout = dout;
        next_oe = oe;
        next_wr_data = wr_data;
        next_instr_valid = 1'b0;
        next_addr_valid = 1'b0;
        next_wr_valid = 1'b0;
        next_rd_req = 1'b0;
        next_cmd_end = 1'b0;
        next_cfg_vol = cfg_wr_i ? cfg_wdata_i : cfg_vol;
        next_stat_vol = stat_wr_i ? stat_wdata_i : stat_vol;
        next_bank = bank_wr_i ? bank_wdata_i : bank;

        if (rst_s2)
        begin
            next_rp_cnt = 8'h00;
        end
        else if (!rst_taken)
        begin
            next_rp_cnt = rp_cnt + 8'h01;
        end

        case (state)
            dqsf_pkg::ST_INIT:
            begin
                if (!rst_s2)
                begin
                    next_pu_cnt = 32'h0000_0000;
                end
                else if (pu_cnt >= PU_CYCLES - 1)
                begin
                    next_state = dqsf_pkg::ST_IDLE;
                end
                else
                begin
                    next_pu_cnt = pu_cnt + 32'h0000_0001;
                end
            end
            dqsf_pkg::ST_IDLE:
            begin
                if (cs_fall)
                begin
                    next_state = dqsf_pkg::ST_INSTR;
                    next_bit_cnt = 4'h0;
                    next_f_ddr = 1'b0;
                end
            end
            dqsf_pkg::ST_INSTR:
            begin
                if (rise)
                begin
                    next_instr = {instr[6:0], io_s2[0]};
                    next_bit_cnt = bit_cnt + 4'h1;
                    if (bit_cnt == `DQSF_INSTR_BITS - 4'h1)
                    begin
                        next_state = dqsf_pkg::ST_DECODE;
                        next_instr_valid = 1'b1;
                    end
                end
            end
            dqsf_pkg::ST_DECODE:
            begin
                if (fall)
                begin
                    next_f_addr_en = fmt_addr_en_i;
                    next_f_addr32 = fmt_addr32_i;
                    next_f_mode_en = fmt_mode_en_i;
                    next_f_ddr = fmt_ddr_i;
                    next_f_read = fmt_read_i;
                    next_f_write = fmt_write_i;
                    next_f_dummy = fmt_dummy_i;
                    next_bit_cnt = 4'h0;
                    next_addr = 32'h0000_0000;
                    if (fmt_addr_en_i)
                    begin
                        next_state = dqsf_pkg::ST_ADDR;
                    end
                    else if (fmt_read_i && fmt_dummy_i == 5'h00)
                    begin
                        next_state = dqsf_pkg::ST_DOUT;
                        next_dout = rd_data_i;
                        next_oe = `DQSF_OE_ALL;
                        next_rd_req = 1'b1;
                    end
                    else
                    begin
                        next_state = data_phase(fmt_read_i, fmt_write_i);
                        next_dmy_cnt = fmt_dummy_i;
                    end
                end
            end
            dqsf_pkg::ST_ADDR:
            begin
                if (cap)
                begin
                    next_addr = {addr[27:0], io_s2[3:0]};
                    next_bit_cnt = bit_cnt + 4'h1;
                    if (bit_cnt == addr_nibs - 4'h1)
                    begin
                        next_addr_valid = 1'b1;
                        next_bit_cnt = 4'h0;
                        if (f_mode_en)
                        begin
                            next_state = dqsf_pkg::ST_MODE;
                        end
                        else
                        begin
                            next_state = data_phase(f_read, f_write);
                            next_dmy_cnt = dummy_load(f_ddr, f_dummy);
                            next_rd_req = f_read;
                        end
                    end
                end
            end
            dqsf_pkg::ST_MODE:
            begin
                if (cap)
                begin
                    next_mode = {mode[3:0], io_s2[3:0]};
                    next_bit_cnt = bit_cnt + 4'h1;
                    if (bit_cnt == `DQSF_NIB_MODE - 4'h1)
                    begin
                        next_state = data_phase(f_read, f_write);
                        next_dmy_cnt = dummy_load(f_ddr, f_dummy);
                        next_rd_req = f_read;
                    end
                end
            end
            dqsf_pkg::ST_DUMMY:
            begin
                if (fall)
                begin
                    if (dmy_cnt == 5'h00)
                    begin
                        next_state = dqsf_pkg::ST_DOUT;
                        next_dout = rd_data_i;
                        next_oe = `DQSF_OE_ALL;
                        next_rd_req = 1'b1;
                    end
                    else
                    begin
                        next_dmy_cnt = dmy_cnt - 5'h01;
                    end
                end
            end
            dqsf_pkg::ST_DIN:
            begin
                if (cap)
                begin
                    next_wr_data = io_s2;
                    next_wr_valid = 1'b1;
                end
            end
            dqsf_pkg::ST_DOUT:
            begin
                if (upd)
                begin
                    next_dout = rd_data_i;
                    next_rd_req = 1'b1;
                end
            end
            dqsf_pkg::ST_DONE:
            begin
                next_state = state;
            end
            default:
            begin
                next_state = dqsf_pkg::ST_IDLE;
            end
        endcase

        if (cs_s2 && state != dqsf_pkg::ST_INIT
            && state != dqsf_pkg::ST_IDLE)
        begin
            next_state = dqsf_pkg::ST_IDLE;
            next_oe = `DQSF_OE_NONE;
            next_cmd_end = 1'b1;
            next_rd_req = 1'b0;
            next_wr_valid = 1'b0;
            next_f_ddr = 1'b0;
        end

        if (!rst_s2 && rst_taken)
        begin
            next_state = dqsf_pkg::ST_INIT;
            next_pu_cnt = 32'h0000_0000;
            next_oe = `DQSF_OE_NONE;
            next_f_ddr = 1'b0;
            next_instr_valid = 1'b0;
            next_addr_valid = 1'b0;
            next_wr_valid = 1'b0;
            next_rd_req = 1'b0;
            next_cmd_end = 1'b0;
            next_cfg_vol = `DQSF_CFG_VOL_RST;
            next_stat_vol = `DQSF_STAT_VOL_RST;
            next_bank = `DQSF_BANK_RST;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            state <= dqsf_pkg::ST_INIT;
            rp_cnt <= 8'h00;
            pu_cnt <= 32'h0000_0000;
            bit_cnt <= 4'h0;
            dmy_cnt <= 5'h00;
            instr <= 8'h00;
            addr <= 32'h0000_0000;
            mode <= 8'h00;
            f_addr_en <= 1'b0;
            f_addr32 <= 1'b0;
            f_mode_en <= 1'b0;
            f_ddr <= 1'b0;
            f_read <= 1'b0;
            f_write <= 1'b0;
            f_dummy <= 5'h00;
            dout <= 8'h00;
            oe <= `DQSF_OE_NONE;
            wr_data <= 8'h00;
            instr_valid <= 1'b0;
            addr_valid <= 1'b0;
            wr_valid <= 1'b0;
            rd_req <= 1'b0;
            cmd_end <= 1'b0;
            cfg_vol <= `DQSF_CFG_VOL_RST;
            stat_vol <= `DQSF_STAT_VOL_RST;
            bank <= `DQSF_BANK_RST;
        end
        else
        begin
            state <= next_state;
            rp_cnt <= next_rp_cnt;
            pu_cnt <= next_pu_cnt;
            bit_cnt <= next_bit_cnt;
            dmy_cnt <= next_dmy_cnt;
            instr <= next_instr;
            addr <= next_addr;
            mode <= next_mode;
            f_addr_en <= next_f_addr_en;
            f_addr32 <= next_f_addr32;
            f_mode_en <= next_f_mode_en;
            f_ddr <= next_f_ddr;
            f_read <= next_f_read;
            f_write <= next_f_write;
            f_dummy <= next_f_dummy;
            dout <= next_dout;
            oe <= next_oe;
            wr_data <= next_wr_data;
            instr_valid <= next_instr_valid;
            addr_valid <= next_addr_valid;
            wr_valid <= next_wr_valid;
            rd_req <= next_rd_req;
            cmd_end <= next_cmd_end;
            cfg_vol <= next_cfg_vol;
            stat_vol <= next_stat_vol;
            bank <= next_bank;
        end
    end

    assign io_o = dout;
    assign io_oe_o = oe;
    assign instr_o = instr;
    assign instr_valid_o = instr_valid;
    assign addr_o = addr;
    assign addr_valid_o = addr_valid;
    assign mode_o = mode;
    assign wr_data_o = wr_data;
    assign wr_valid_o = wr_valid;
    assign rd_req_o = rd_req;
    assign cmd_end_o = cmd_end;
    assign cfg_vol_o = cfg_vol;
    assign stat_vol_o = stat_vol;
    assign bank_addr_o = bank;
    // core refills its program buffer with ones while this is high.
    assign prog_buf_fill_o = (state == dqsf_pkg::ST_INIT);
    assign init_busy_o = (state == dqsf_pkg::ST_INIT);
    assign active_power_o = ~cs_s2;
    assign standby_o = cs_s2 & ~embedded_busy_i
        & (state != dqsf_pkg::ST_INIT);

endmodule : dqsf_frontend

/* testbench/dqsf_frontend_chk.sv */
`timescale 1ns/100ps
module dqsf_frontend_chk #(
    parameter int unsigned PU_CYCLES = 50
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // Link and core inputs
    input wire logic hw_reset_n_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic fmt_ddr_i,
    input wire logic embedded_busy_i,
    // Design outputs
    input wire logic [7:0] io_o,
    input wire logic [7:0] io_oe_o,
    input wire logic instr_valid_o,
    input wire logic addr_valid_o,
    input wire logic wr_valid_o,
    input wire logic cmd_end_o,
    input wire logic [7:0] cfg_vol_o,
    input wire logic [7:0] stat_vol_o,
    input wire logic [7:0] bank_addr_o,
    input wire logic prog_buf_fill_o,
    input wire logic init_busy_o,
    input wire logic active_power_o,
    input wire logic standby_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!arst_n_i);

    logic [7:0] hold_cnt, next_hold_cnt;
    logic [15:0] init_cnt, next_init_cnt;

    // The pin count saturates so a long reset never wraps into a short one.
    always_comb
    begin
        next_hold_cnt = hold_cnt + {7'h00, hold_cnt != 8'hFF};
        if (hw_reset_n_i)
            next_hold_cnt = 8'h00;
        next_init_cnt = init_cnt + 16'h0001;
        if (!hw_reset_n_i || !init_busy_o)
            next_init_cnt = 16'h0000;
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            hold_cnt <= 8'h00;
            init_cnt <= 16'h0000;
        end
        else
        begin
            hold_cnt <= next_hold_cnt;
            init_cnt <= next_init_cnt;
        end
    end

    sequence s_desel;
        cs_n_i [*6];
    endsequence
    sequence s_sel;
        !cs_n_i [*6];
    endsequence

    property p_desel_float;
        s_desel |-> io_oe_o == 8'h00;
    endproperty
    a_desel_float: assert property (p_desel_float)
        else $error("Driven while deselected.");
    property p_desel_quiet;
        s_desel |-> !(instr_valid_o || addr_valid_o || wr_valid_o);
    endproperty
    a_desel_quiet: assert property (p_desel_quiet)
        else $error("Capture while deselected.");
    property p_oe_whole;
        io_oe_o == 8'h00 || io_oe_o == 8'hFF;
    endproperty
    a_oe_whole: assert property (p_oe_whole)
        else $error("Lines enabled piecemeal.");
    property p_reset_float;
        hold_cnt >= 8'h1A |-> io_oe_o == 8'h00 && init_busy_o
            && prog_buf_fill_o;
    endproperty
    a_reset_float: assert property (p_reset_float)
        else $error("Pin reset did not float or init.");
    property p_reset_regs;
        hold_cnt >= 8'h1A |-> cfg_vol_o == 8'h00 && stat_vol_o == 8'h00
            && bank_addr_o == 8'h00;
    endproperty
    a_reset_regs: assert property (p_reset_regs)
        else $error("Reset left registers set.");
    property p_init_len;
        $fell(init_busy_o) |-> init_cnt >= PU_CYCLES - 1
            && init_cnt <= PU_CYCLES + 8;
    endproperty
    a_init_len: assert property (p_init_len)
        else $error("Init length wrong.");
    property p_sel_active;
        s_sel |-> active_power_o && !standby_o;
    endproperty
    a_sel_active: assert property (p_sel_active)
        else $error("Selected but not active.");
    property p_standby;
        (cs_n_i && !embedded_busy_i && !init_busy_o) [*6] |-> standby_o;
    endproperty
    a_standby: assert property (p_standby)
        else $error("Idle but not in standby.");
    property p_oe_on_fall;
        $rose(io_oe_o[0]) |-> !cs_n_i && !sclk_i && !$past(sclk_i, 1)
            && $past(sclk_i, 7);
    endproperty
    a_oe_on_fall: assert property (p_oe_on_fall)
        else $error("Drive began off a fall.");
    property p_upd_on_edge;
        $changed(io_o) && io_oe_o == 8'hFF && $past(io_oe_o) == 8'hFF
            |-> $past(sclk_i, 1) != $past(sclk_i, 7)
            && (fmt_ddr_i || !$past(sclk_i, 1));
    endproperty
    a_upd_on_edge: assert property (p_upd_on_edge)
        else $error("Output moved off edge.");
    property p_end_pulse;
        io_oe_o == 8'hFF ##1 $rose(cs_n_i) |-> ##[1:6] cmd_end_o;
    endproperty
    a_end_pulse: assert property (p_end_pulse)
        else $error("No end pulse.");
endmodule : dqsf_frontend_chk

bind dqsf_frontend dqsf_frontend_chk #(.PU_CYCLES(PU_CYCLES)) u_chk (.*);

/* testbench/dqsf_host_model.sv */
`timescale 1ns/100ps
module dqsf_host_model (
    // Bench clock
    input wire logic clk_i,
    // Link pins toward the device
    output logic sclk_o,
    output logic cs_n_o,
    output logic [7:0] io_o
);
    logic park = 1'b0;

    initial {sclk_o, cs_n_o, io_o} = 10'h100;

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_i);
    endtask : wait_clk

    // data set a quarter period ahead
    task automatic edge_to(input logic lvl, input logic [7:0] v);
        wait_clk(4);
        io_o <= v;
        wait_clk(4);
        sclk_o <= lvl;
    endtask : edge_to

    task automatic select(input logic mode3);
        park = mode3;
        wait_clk(4);
        sclk_o <= mode3;
        wait_clk(8);
        cs_n_o <= 1'b0;
    endtask : select

    task automatic deselect();
        edge_to(park, ~io_o);
        wait_clk(4);
        cs_n_o <= 1'b1;
        wait_clk(4);
        // Released lines toggle so a stale level never looks valid.
        io_o <= ~io_o;
    endtask : deselect

    task automatic send_byte(input logic [7:0] b);
        edge_to(1'b0, b);
        edge_to(1'b1, b);
    endtask : send_byte

    // instruction on the lowest line of each lane
    task automatic send_instr(input logic [7:0] b);
        for (int i = 7; i >= 0; i--)
            send_byte({i[2:0], b[i], ~i[2:0], b[i]});
    endtask : send_instr

    // nibbles first to last, copied on lane two
    task automatic send_nibs(input logic [31:0] a, input int n,
        input logic ddr);
        logic [3:0] nb;
        if (ddr)
            edge_to(1'b0, ~io_o);
        for (int k = 0; k < n; k++)
        begin
            nb = a[4 * (n - 1 - k) +: 4];
            if (ddr)
                edge_to(~k[0], {nb, nb});
            else
                send_byte({nb, nb});
        end
    endtask : send_nibs

    task automatic clocks(input int n);
        repeat (n) send_byte(~io_o);
    endtask : clocks
endmodule : dqsf_host_model

/* testbench/dqsf_frontend_bench.sv */
`timescale 1ns/100ps
`define CHK(nm, ex, got) \
    begin \
        compares++; \
        if ((got) !== (ex)) \
        begin \
            failures++; \
            $display("BAD %s expected %0h seen %0h", nm, ex, got); \
        end \
    end

module dqsf_frontend_bench;
    localparam int unsigned PU = 50;
    logic clk_i = 1'b0;
    logic arst_n_i, hw_reset_n_i, sclk_i, cs_n_i, instr_valid_o;
    logic [7:0] host_io, io_i, io_o, io_oe_o, instr_o, mode_o, wr_data_o;
    logic fmt_addr_en_i, fmt_addr32_i, fmt_mode_en_i, fmt_ddr_i;
    logic fmt_read_i, fmt_write_i, addr_valid_o, wr_valid_o;
    logic [4:0] fmt_dummy_i;
    logic [31:0] addr_o;
    logic [7:0] rd_data_i, cfg_wdata_i, stat_wdata_i, bank_wdata_i;
    logic cfg_wr_i, stat_wr_i, bank_wr_i, embedded_busy_i;
    logic [7:0] cfg_vol_o, stat_vol_o, bank_addr_o, last_wr;
    logic rd_req_o, cmd_end_o, prog_buf_fill_o, init_busy_o;
    logic active_power_o, standby_o;
    int failures, compares, n_iv, n_wr;

    always #5 clk_i = ~clk_i;
    assign io_i = (io_oe_o & io_o) | (~io_oe_o & host_io);

    dqsf_frontend #(.PU_CYCLES(PU)) i_dqsf_frontend (.*);
    dqsf_host_model host (
        .clk_i, .sclk_o(sclk_i), .cs_n_o(cs_n_i), .io_o(host_io)
    );

    always @(posedge clk_i)
    begin
        if (instr_valid_o)
            n_iv <= n_iv + 1;
        if (wr_valid_o)
        begin
            n_wr <= n_wr + 1;
            last_wr <= wr_data_o;
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : cyc

    task automatic report_and_stop();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop

    task automatic set_fmt(input logic [5:0] f, input logic [4:0] d);
        @(posedge clk_i);
        {fmt_addr_en_i, fmt_addr32_i, fmt_mode_en_i, fmt_ddr_i} <= f[5:2];
        {fmt_read_i, fmt_write_i} <= f[1:0];
        fmt_dummy_i <= d;
    endtask : set_fmt

    task automatic read_cmd(input logic m3, input logic ddr,
        input logic a32, input logic [4:0] nd);
        logic [7:0] ins, rb;
        logic [31:0] ad;
        ins = 8'($urandom);
        rb = 8'($urandom);
        ad = $urandom;
        set_fmt({1'b1, a32, 1'b0, ddr, 2'b10}, nd);
        rd_data_i <= rb;
        host.select(m3);
        host.send_instr(ins);
        cyc(6);
        `CHK("instr", ins, instr_o)
        host.send_nibs(ad, a32 ? 8 : 6, ddr);
        cyc(6);
        `CHK("addr", a32 ? ad : ad & 32'h00FFFFFF, addr_o)
        host.clocks(int'(nd) + 2);
        cyc(6);
        `CHK("drive", 8'hFF, io_oe_o)
        `CHK("rdata", rb, io_o)
        host.deselect();
        cyc(8);
        `CHK("float", 8'h00, io_oe_o)
    endtask : read_cmd

    task automatic write_cmd(input logic m3);
        logic [7:0] wb;
        logic [31:0] ad;
        int n0;
        wb = 8'($urandom);
        ad = $urandom;
        n0 = n_wr;
        set_fmt(6'b111001, 5'h00);
        host.select(m3);
        host.send_instr(8'($urandom));
        host.send_nibs(ad, 8, 1'b0);
        host.send_nibs({24'h0, wb}, 2, 1'b0);
        host.send_byte(~wb);
        host.send_byte(wb);
        cyc(6);
        `CHK("mode", wb, mode_o)
        `CHK("addr32", ad, addr_o)
        `CHK("wr_count", n0 + 2, n_wr)
        `CHK("wr_data", wb, last_wr)
        host.deselect();
    endtask : write_cmd

    initial
    begin
        logic [31:0] r;
        {arst_n_i, cfg_wr_i, stat_wr_i, bank_wr_i, embedded_busy_i} = 5'h00;
        hw_reset_n_i = 1'b1;
        r = $urandom(32'h514B);
        host.select(1'b0);
        repeat (4) @(posedge clk_i);
        arst_n_i <= 1'b1;
        cyc(2);
        `CHK("init", 1'b1, init_busy_o)
        cyc(PU + 20);
        host.send_instr(8'hA5);
        cyc(6);
        `CHK("no_cmd", 0, n_iv)
        `CHK("active", 1'b1, active_power_o)
        host.deselect();
        host.clocks(8);
        cyc(6);
        `CHK("ignored", 0, n_iv)
        `CHK("standby", 1'b1, standby_o)
        `CHK("regs0", 24'h0, {cfg_vol_o, stat_vol_o, bank_addr_o})
        @(posedge clk_i);
        embedded_busy_i <= 1'b1;
        cyc(6);
        `CHK("busy", 1'b0, standby_o)
        @(posedge clk_i);
        embedded_busy_i <= 1'b0;
        for (int k = 0; k < 8; k++)
            read_cmd(k[0], k[1], k[2], 5'(k[1]) + 5'(k[2]));
        write_cmd(1'b0);
        write_cmd(1'b1);
        r = $urandom | 32'h00010101;
        @(posedge clk_i);
        {cfg_wr_i, stat_wr_i, bank_wr_i} <= 3'h7;
        {cfg_wdata_i, stat_wdata_i, bank_wdata_i} <= r[23:0];
        @(posedge clk_i);
        {cfg_wr_i, stat_wr_i, bank_wr_i} <= 3'h0;
        hw_reset_n_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        hw_reset_n_i <= 1'b1;
        cyc(4);
        `CHK("regs", r[23:0], {cfg_vol_o, stat_vol_o, bank_addr_o})
        `CHK("short_rst", 1'b0, init_busy_o)
        set_fmt(6'b000010, 5'h00);
        host.select(1'b0);
        host.send_instr(8'($urandom));
        host.clocks(2);
        cyc(6);
        `CHK("drive0", 8'hFF, io_oe_o)
        @(posedge clk_i);
        hw_reset_n_i <= 1'b0;
        cyc(30);
        `CHK("rst_float", 8'h00, io_oe_o)
        `CHK("rst_regs", 24'h0, {cfg_vol_o, stat_vol_o, bank_addr_o})
        `CHK("rst_fill", 1'b1, prog_buf_fill_o)
        @(posedge clk_i);
        hw_reset_n_i <= 1'b1;
        host.deselect();
        cyc(PU + 20);
        `CHK("ready", 1'b0, init_busy_o)
        read_cmd(1'b1, 1'b0, 1'b0, 5'h02);
        report_and_stop();
    end

    initial
    begin
        repeat (60000) @(posedge clk_i);
        failures++;
        report_and_stop();
    end
endmodule : dqsf_frontend_bench
